// ==== rtl/sssr_evset.v ====
// one status register set: condition, latched event and enable registers with summary
// assumes event inputs are one-cycle pulses synchronous to mclk
`timescale 1ns/1ps
`include "sssr_map.vh"

module sssr_evset (
  input wire mclk,
  input wire reset,
  input wire [15:0] cond_in,
  input wire [15:0] event_pulse,
  input wire event_clear,
  input wire enable_wr,
  input wire [15:0] enable_wdata,
  input wire enable_clear,
  output reg [15:0] cond,
  output reg [15:0] event_bits,
  output reg [15:0] enable,
  output wire summary
);

  always @(posedge mclk) begin
    if (reset) begin
      cond <= `SSSR_RST16;
      event_bits <= `SSSR_RST16;
      enable <= `SSSR_RST16;
    end else begin
      cond <= cond_in;
      // set beats clear on the same bit
      if (event_clear)
        event_bits <= event_pulse;
      else
        event_bits <= event_bits | event_pulse;
      if (enable_wr)
        enable <= enable_wdata;
      else if (enable_clear)
        enable <= `SSSR_RST16;
    end
  end

  assign summary = |(event_bits & enable);

endmodule

// ==== rtl/sssr_map.vh ====
// register map, command bits, status byte layout and queue sizes of the status block
// assumes the includer is a plain verilog-2005 module clocked by mclk
//
// Functional notes
// - condition registers read-only, track live conditions
// - event pulse sets event bit until read or clear-status
// - enabled event bit drives set summary bit
// - enabled status byte summary sets master summary
// - four sets and two queues feed byte
// - query responses and errors enter their queues
// - power-on clears all registers, empties queues
// - clear-status resets all four event registers
// - three clear commands empty the error queue
// - status preset clears three enables, keeps errors
// - standard enable immune to preset and clear
// - system preset and reset change nothing here
// - writing zero clears that enable register
// - only enable registers are host writable
// - decimal parameter bit n has weight 2^n
// - status byte summaries follow sources, never latch
// - byte bits zero and two to seven assigned
// - serial poll clears request, not master summary
`ifndef SSSR_MAP_VH
`define SSSR_MAP_VH

`define SSSR_ADDR_W 5
`define SSSR_DATA_W 16

`define SSSR_OFF_STB 5'h00
`define SSSR_OFF_SRE 5'h01
`define SSSR_OFF_STD_EVT 5'h02
`define SSSR_OFF_STD_ENA 5'h03
`define SSSR_OFF_OPR_CND 5'h04
`define SSSR_OFF_OPR_EVT 5'h05
`define SSSR_OFF_OPR_ENA 5'h06
`define SSSR_OFF_MEA_CND 5'h07
`define SSSR_OFF_MEA_EVT 5'h08
`define SSSR_OFF_MEA_ENA 5'h09
`define SSSR_OFF_QUE_CND 5'h0a
`define SSSR_OFF_QUE_EVT 5'h0b
`define SSSR_OFF_QUE_ENA 5'h0c
`define SSSR_OFF_CMD 5'h0d
`define SSSR_OFF_OUTQ 5'h0e
`define SSSR_OFF_ERRQ 5'h0f
`define SSSR_OFF_SPOLL 5'h10
`define SSSR_OFF_QLVL 5'h11

`define SSSR_CMD_CLS 0
`define SSSR_CMD_PRESET 1
`define SSSR_CMD_QCLR 2
`define SSSR_CMD_SYSCLR 3
`define SSSR_CMD_SYSPRESET 4
`define SSSR_CMD_RST 5

`define SSSR_STB_MEAS 0
`define SSSR_STB_EAV 2
`define SSSR_STB_QUES 3
`define SSSR_STB_MAV 4
`define SSSR_STB_ESB 5
`define SSSR_STB_MSS 6
`define SSSR_STB_OSB 7

`define SSSR_RST16 16'h0000
`define SSSR_RST8 8'h00
`define SSSR_STB_USED 8'hbd

`define SSSR_Q_DEPTH 4
`define SSSR_Q_PTR_W 2
`define SSSR_Q_CNT_W 3
`define SSSR_Q_DATA_W 8

`endif

// ==== rtl/sssr_top.v ====
// status summary and service request block: four register sets, two queues, status byte
// assumes a one-cycle strobe register port; inputs synchronous to mclk
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "sssr_map.vh"

module sssr_top (
  input wire mclk,
  input wire reset,
  input wire [4:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire [7:0] std_event_pulse,
  input wire [15:0] oper_cond_in,
  input wire [15:0] oper_event_pulse,
  input wire [15:0] meas_cond_in,
  input wire [15:0] meas_event_pulse,
  input wire [15:0] ques_cond_in,
  input wire [15:0] ques_event_pulse,
  input wire resp_push,
  input wire [7:0] resp_data,
  input wire err_push,
  input wire [7:0] err_data,
  output reg [7:0] status_byte,
  output reg master_summary_flag,
  output reg request_service_flag,
  output reg error_queue_nonempty,
  output reg questionable_summary,
  output reg standard_event_summary,
  output reg operation_summary
);

  localparam [`SSSR_Q_CNT_W-1:0] Q_FULL = `SSSR_Q_DEPTH;
  localparam [`SSSR_Q_CNT_W-1:0] Q_ONE = 1;

  // bus decode
  wire wr_sre = wr && (addr == `SSSR_OFF_SRE);
  wire wr_std = wr && (addr == `SSSR_OFF_STD_ENA);
  wire wr_opr = wr && (addr == `SSSR_OFF_OPR_ENA);
  wire wr_mea = wr && (addr == `SSSR_OFF_MEA_ENA);
  wire wr_que = wr && (addr == `SSSR_OFF_QUE_ENA);
  wire wr_cmd = wr && (addr == `SSSR_OFF_CMD);
  wire rd_std = rd && (addr == `SSSR_OFF_STD_EVT);
  wire rd_opr = rd && (addr == `SSSR_OFF_OPR_EVT);
  wire rd_mea = rd && (addr == `SSSR_OFF_MEA_EVT);
  wire rd_que = rd && (addr == `SSSR_OFF_QUE_EVT);
  wire rd_outq = rd && (addr == `SSSR_OFF_OUTQ);
  wire rd_errq = rd && (addr == `SSSR_OFF_ERRQ);
  wire rd_spoll = rd && (addr == `SSSR_OFF_SPOLL);

  // command strobes; system preset and reset common reach nothing here
  wire cmd_cls = wr_cmd && wdata[`SSSR_CMD_CLS];
  wire cmd_preset = wr_cmd && wdata[`SSSR_CMD_PRESET];
  wire cmd_qclr = wr_cmd && wdata[`SSSR_CMD_QCLR];
  wire cmd_sysclr = wr_cmd && wdata[`SSSR_CMD_SYSCLR];
  wire err_flush = cmd_cls || cmd_qclr || cmd_sysclr;

  wire [15:0] std_cond;
  wire [15:0] std_evt;
  wire [15:0] std_ena;
  wire [15:0] opr_cond;
  wire [15:0] opr_evt;
  wire [15:0] opr_ena;
  wire [15:0] mea_cond;
  wire [15:0] mea_evt;
  wire [15:0] mea_ena;
  wire [15:0] que_cond;
  wire [15:0] que_evt;
  wire [15:0] que_ena;
  wire std_sum;
  wire opr_sum;
  wire mea_sum;
  wire que_sum;

  // standard set: enable untouched by preset or clear-status
  sssr_evset u_std (
    .mclk(mclk),
    .reset(reset),
    .cond_in(16'h0000),
    .event_pulse({8'h00, std_event_pulse}),
    .event_clear(rd_std || cmd_cls),
    .enable_wr(wr_std),
    .enable_wdata(wdata),
    .enable_clear(1'b0),
    .cond(std_cond),
    .event_bits(std_evt),
    .enable(std_ena),
    .summary(std_sum)
  );

  sssr_evset u_opr (
    .mclk(mclk),
    .reset(reset),
    .cond_in(oper_cond_in),
    .event_pulse(oper_event_pulse),
    .event_clear(rd_opr || cmd_cls),
    .enable_wr(wr_opr),
    .enable_wdata(wdata),
    .enable_clear(cmd_preset),
    .cond(opr_cond),
    .event_bits(opr_evt),
    .enable(opr_ena),
    .summary(opr_sum)
  );

  sssr_evset u_mea (
    .mclk(mclk),
    .reset(reset),
    .cond_in(meas_cond_in),
    .event_pulse(meas_event_pulse),
    .event_clear(rd_mea || cmd_cls),
    .enable_wr(wr_mea),
    .enable_wdata(wdata),
    .enable_clear(cmd_preset),
    .cond(mea_cond),
    .event_bits(mea_evt),
    .enable(mea_ena),
    .summary(mea_sum)
  );

  sssr_evset u_que (
    .mclk(mclk),
    .reset(reset),
    .cond_in(ques_cond_in),
    .event_pulse(ques_event_pulse),
    .event_clear(rd_que || cmd_cls),
    .enable_wr(wr_que),
    .enable_wdata(wdata),
    .enable_clear(cmd_preset),
    .cond(que_cond),
    .event_bits(que_evt),
    .enable(que_ena),
    .summary(que_sum)
  );

  // output queue
  reg [7:0] outq_mem [0:`SSSR_Q_DEPTH-1];
  reg [`SSSR_Q_PTR_W-1:0] outq_head;
  reg [`SSSR_Q_CNT_W-1:0] outq_cnt;
  wire outq_pop = rd_outq && (outq_cnt != 0);
  wire outq_put = resp_push && ((outq_cnt != Q_FULL) || outq_pop);
  wire [`SSSR_Q_CNT_W-1:0] outq_wsum = {1'b0, outq_head} + outq_cnt;
  wire [`SSSR_Q_PTR_W-1:0] outq_wptr = outq_wsum[`SSSR_Q_PTR_W-1:0];

  // error queue
  reg [7:0] errq_mem [0:`SSSR_Q_DEPTH-1];
  reg [`SSSR_Q_PTR_W-1:0] errq_head;
  reg [`SSSR_Q_CNT_W-1:0] errq_cnt;
  wire errq_pop = rd_errq && (errq_cnt != 0);
  wire errq_put = err_push && ((errq_cnt != Q_FULL) || errq_pop || err_flush);
  wire [`SSSR_Q_CNT_W-1:0] errq_wsum = {1'b0, errq_head} + errq_cnt;
  wire [`SSSR_Q_PTR_W-1:0] errq_wptr = errq_wsum[`SSSR_Q_PTR_W-1:0];

  integer i;

  always @(posedge mclk) begin
    if (reset) begin
      outq_head <= {`SSSR_Q_PTR_W{1'b0}};
      outq_cnt <= {`SSSR_Q_CNT_W{1'b0}};
      for (i = 0; i < `SSSR_Q_DEPTH; i = i + 1)
        outq_mem[i] <= `SSSR_RST8;
    end else begin
      if (outq_put)
        outq_mem[outq_wptr] <= resp_data;
      if (outq_pop)
        outq_head <= outq_head + 2'd1;
      if (outq_put && !outq_pop)
        outq_cnt <= outq_cnt + Q_ONE;
      else if (outq_pop && !outq_put)
        outq_cnt <= outq_cnt - Q_ONE;
    end
  end

  // a push in the flush cycle survives as the only entry
  always @(posedge mclk) begin
    if (reset) begin
      errq_head <= {`SSSR_Q_PTR_W{1'b0}};
      errq_cnt <= {`SSSR_Q_CNT_W{1'b0}};
      for (i = 0; i < `SSSR_Q_DEPTH; i = i + 1)
        errq_mem[i] <= `SSSR_RST8;
    end else if (err_flush) begin
      errq_head <= {`SSSR_Q_PTR_W{1'b0}};
      errq_cnt <= err_push ? Q_ONE : {`SSSR_Q_CNT_W{1'b0}};
      if (err_push)
        errq_mem[0] <= err_data;
    end else begin
      if (errq_put)
        errq_mem[errq_wptr] <= err_data;
      if (errq_pop)
        errq_head <= errq_head + 2'd1;
      if (errq_put && !errq_pop)
        errq_cnt <= errq_cnt + Q_ONE;
      else if (errq_pop && !errq_put)
        errq_cnt <= errq_cnt - Q_ONE;
    end
  end

  // status byte, evaluated every cycle from live summaries
  reg [7:0] sre;
  reg [7:0] en_sum_prev;
  reg [7:0] next_sum;
  reg [7:0] next_en_sum;
  reg next_mss;

  always @* begin
    next_sum = 8'h00;
    next_sum[`SSSR_STB_MEAS] = mea_sum;
    next_sum[`SSSR_STB_EAV] = (errq_cnt != 0);
    next_sum[`SSSR_STB_QUES] = que_sum;
    next_sum[`SSSR_STB_MAV] = (outq_cnt != 0);
    next_sum[`SSSR_STB_ESB] = std_sum;
    next_sum[`SSSR_STB_OSB] = opr_sum;
    next_en_sum = next_sum & sre & `SSSR_STB_USED;
    next_mss = |next_en_sum;
  end

  always @(posedge mclk) begin
    if (reset) begin
      sre <= `SSSR_RST8;
      en_sum_prev <= `SSSR_RST8;
      status_byte <= `SSSR_RST8;
      master_summary_flag <= 1'b0;
      request_service_flag <= 1'b0;
      error_queue_nonempty <= 1'b0;
      questionable_summary <= 1'b0;
      standard_event_summary <= 1'b0;
      operation_summary <= 1'b0;
    end else begin
      if (wr_sre)
        sre <= wdata[7:0];
      en_sum_prev <= next_en_sum;
      status_byte <= {next_sum[7], next_mss, next_sum[5:0]};
      master_summary_flag <= next_mss;
      error_queue_nonempty <= next_sum[`SSSR_STB_EAV];
      questionable_summary <= next_sum[`SSSR_STB_QUES];
      standard_event_summary <= next_sum[`SSSR_STB_ESB];
      operation_summary <= next_sum[`SSSR_STB_OSB];
      // newly enabled summary raises request; poll clears, new rise wins
      if (|(next_en_sum & ~en_sum_prev))
        request_service_flag <= 1'b1;
      else if (rd_spoll)
        request_service_flag <= 1'b0;
    end
  end

  // read port: data valid the cycle after the strobe, unmapped reads zero
  reg [15:0] next_rdata;

  always @* begin
    next_rdata = 16'h0000;
    case (addr)
      `SSSR_OFF_STB: next_rdata = {8'h00, status_byte};
      `SSSR_OFF_SRE: next_rdata = {8'h00, sre};
      `SSSR_OFF_STD_EVT: next_rdata = std_evt;
      `SSSR_OFF_STD_ENA: next_rdata = std_ena;
      `SSSR_OFF_OPR_CND: next_rdata = opr_cond;
      `SSSR_OFF_OPR_EVT: next_rdata = opr_evt;
      `SSSR_OFF_OPR_ENA: next_rdata = opr_ena;
      `SSSR_OFF_MEA_CND: next_rdata = mea_cond;
      `SSSR_OFF_MEA_EVT: next_rdata = mea_evt;
      `SSSR_OFF_MEA_ENA: next_rdata = mea_ena;
      `SSSR_OFF_QUE_CND: next_rdata = que_cond;
      `SSSR_OFF_QUE_EVT: next_rdata = que_evt;
      `SSSR_OFF_QUE_ENA: next_rdata = que_ena;
      `SSSR_OFF_OUTQ: next_rdata = (outq_cnt != 0) ? {8'h00, outq_mem[outq_head]} : 16'h0000;
      `SSSR_OFF_ERRQ: next_rdata = (errq_cnt != 0) ? {8'h00, errq_mem[errq_head]} : 16'h0000;
      `SSSR_OFF_SPOLL: next_rdata = {8'h00, status_byte[7], request_service_flag,
                                     status_byte[5:0]};
      `SSSR_OFF_QLVL: next_rdata = {5'h00, errq_cnt, 5'h00, outq_cnt};
      default: next_rdata = 16'h0000;
    endcase
  end

  always @(posedge mclk) begin
    if (reset)
      rdata <= `SSSR_RST16;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= `SSSR_RST16;
  end

  // std_cond is unused; the standard set has no live condition
  wire unused_std = |std_cond;

endmodule

// ==== tb/sssr_checker.sv ====
// port-level assertions on the status summary block
// assumes bind onto sssr_top, single clock mclk, sync reset
`timescale 1ns/1ps

module sssr_checker (
  input wire mclk,
  input wire reset,
  input wire [15:0] rdata,
  input wire wr,
  input wire err_push,
  input wire resp_push,
  input wire [7:0] status_byte,
  input wire master_summary_flag,
  input wire request_service_flag,
  input wire standard_event_summary
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_mss_bit; master_summary_flag == status_byte[6]; endproperty
  a_mss_bit: assert property (p_mss_bit) else $error("master flag differs from byte");
  property p_unused; status_byte[1] == 1'b0; endproperty
  a_unused: assert property (p_unused) else $error("unused byte bit set");
  property p_por; $fell(reset) |-> status_byte == 8'h00 && !request_service_flag; endproperty
  a_por: assert property (p_por) else $error("status not clear after reset");
  property p_eav; err_push |-> ##2 status_byte[2]; endproperty
  a_eav: assert property (p_eav) else $error("error entry not flagged");
  property p_mav; resp_push |-> ##2 status_byte[4]; endproperty
  a_mav: assert property (p_mav) else $error("response not flagged");
  property p_esb; standard_event_summary == status_byte[5]; endproperty
  a_esb: assert property (p_esb) else $error("standard summary latched");
  property p_src; master_summary_flag |-> (status_byte & 8'hbd) != 8'h00; endproperty
  a_src: assert property (p_src) else $error("master flag without summary");
  property p_rqs; $rose(request_service_flag) |-> master_summary_flag; endproperty
  a_rqs: assert property (p_rqs) else $error("request without master flag");
  property p_wr_quiet; wr |=> rdata == 16'h0000; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write returned data");
endmodule

bind sssr_top sssr_checker chk_u (.*);

// ==== tb/sssr_host.sv ====
// host model: strobe register port master with write and read tasks
// assumes callers start each task right after a rising edge of mclk
`timescale 1ns/1ps

module sssr_host (
  input wire mclk,
  input wire [15:0] rdata,
  output logic [4:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 5'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    wdata <= ~d;
    @(posedge mclk);
  endtask

  task automatic rreg(input logic [4:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask
endmodule

// ==== tb/test_status_summary_service_request.sv ====
// self-checking bench for the status summary block
// assumes host model drives the register port, bench drives event sources
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch %0t got %h", $time, a); end end

module test_status_summary_service_request;
  logic mclk = 0, reset = 1, wr, rd, resp_push = 0, err_push = 0;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, v;
  logic [7:0] std_event_pulse = 0, resp_data = 0, err_data = 0, status_byte;
  logic [15:0] oper_cond_in = 0, oper_event_pulse = 0, meas_cond_in = 0;
  logic [15:0] meas_event_pulse = 0, ques_cond_in = 0, ques_event_pulse = 0;
  logic master_summary_flag, request_service_flag, error_queue_nonempty;
  logic questionable_summary, standard_event_summary, operation_summary;
  int n_fail = 0, check_count = 0;

  sssr_top dut_u (.*);
  sssr_host h_u (.*);

  initial forever #20 mclk = ~mclk;

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic conclude;
    $display("fails %0d checks %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic s_power;
    for (int a = 0; a < 18; a++) begin
      h_u.rreg(a[4:0], v);
      `CHK(v, 16'h0000)
    end
  endtask

  task automatic s_oper;
    oper_cond_in <= 16'h8001;
    cyc(1);
    h_u.rreg(5'h04, v);
    `CHK(v, 16'h8001)
    oper_event_pulse <= 16'h8008;
    cyc(1);
    oper_event_pulse <= 16'h0000;
    h_u.wreg(5'h06, 16'd32768);
    cyc(2);
    `CHK(operation_summary, 1'b1)
    `CHK(status_byte[7], 1'b1)
    h_u.wreg(5'h01, 16'h0080);
    cyc(2);
    `CHK(request_service_flag, 1'b1)
    h_u.rreg(5'h10, v);
    `CHK(v[6], 1'b1)
    cyc(1);
    `CHK({request_service_flag, master_summary_flag}, 2'b01)
    h_u.rreg(5'h05, v);
    `CHK(v, 16'h8008)
    cyc(2);
    `CHK(status_byte, 8'h00)
  endtask

  task automatic s_cmds;
    h_u.wreg(5'h03, 16'h00ff);
    h_u.wreg(5'h09, 16'h0001);
    h_u.wreg(5'h0c, 16'h0001);
    {std_event_pulse, meas_event_pulse, ques_event_pulse} <= {8'h01, 16'h0001, 16'h0001};
    {err_push, err_data} <= {1'b1, 8'h5a};
    cyc(1);
    {std_event_pulse, meas_event_pulse, ques_event_pulse, err_push} <= '0;
    h_u.wreg(5'h0d, 16'h0030);
    cyc(2);
    `CHK(status_byte, 8'h2d)
    `CHK(questionable_summary, 1'b1)
    h_u.wreg(5'h0d, 16'h0002);
    h_u.rreg(5'h09, v);
    `CHK(v, 16'h0000)
    h_u.rreg(5'h03, v);
    `CHK(v, 16'h00ff)
    `CHK(error_queue_nonempty, 1'b1)
    h_u.wreg(5'h0d, 16'h0001);
    cyc(2);
    `CHK(status_byte, 8'h00)
    h_u.rreg(5'h0b, v);
    `CHK(v, 16'h0000)
    for (int b = 2; b < 4; b++) begin
      err_push <= 1'b1;
      cyc(1);
      err_push <= 1'b0;
      h_u.wreg(5'h0d, 16'h0001 << b);
      cyc(2);
      `CHK(error_queue_nonempty, 1'b0)
    end
    h_u.wreg(5'h03, 16'h0000);
    h_u.rreg(5'h03, v);
    `CHK(v, 16'h0000)
    h_u.wreg(5'h02, 16'hffff);
    h_u.rreg(5'h02, v);
    `CHK(v, 16'h0000)
  endtask

  task automatic s_race;
    std_event_pulse <= 8'h01;
    fork
      h_u.wreg(5'h0d, 16'h0001);
      begin cyc(1); std_event_pulse <= 8'h00; end
    join
    h_u.rreg(5'h02, v);
    `CHK(v, 16'h0001)
  endtask

  task automatic s_queue;
    {resp_push, resp_data} <= {1'b1, 8'h3c};
    cyc(1);
    resp_push <= 1'b0;
    cyc(2);
    `CHK(status_byte[4], 1'b1)
    h_u.rreg(5'h0e, v);
    `CHK(v, 16'h003c)
    cyc(2);
    `CHK(status_byte[4], 1'b0)
  endtask

  initial begin
    cyc(20000);
    n_fail++;
    conclude();
  end

  initial begin
    cyc(5);
    reset <= 1'b0;
    s_power();
    s_oper();
    s_cmds();
    s_race();
    s_queue();
    conclude();
  end
endmodule
